// ### chip_select_decoder.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Each peripheral select asserts over its own 256-byte window, with bus cycle timing.
// - Lines 0-3 in consecutive windows from base; 1024-1279 unused; lines 5, 6 follow.
// - Peripheral register bits 15-7 hold base address bits 19-11.
// - Lines 0-3 wait code maps 0,1,2,3,5,7,9,15 wait states.
// - Lines 0-3 ready bit set ignores external ready; waits still inserted.
// - Peripheral selects stay inactive until peripheral and auxiliary registers are written.
// - Lines 5, 6 take 0-3 waits, ready mode and space from auxiliary register.
// - Low select disabled after reset, enabled by any write; block starts at zero.
// - Low boundary field sets block end 0FFFFh, 1FFFFh, 3FFFFh or 7FFFFh.
// - Low register address-off bit stops driving the multiplexed address; resets to zero.
// - Upper register address-off bit stops address drive during upper select cycles.
// - Strap low at reset release forces the multiplexed address always driven.
// - Low register bit 6 enables refreshed RAM mode; refresh set up first.
// - Low select ready bit ignores ready when set; bits 1-0 give 0-3 waits.
// - Upper select active after reset at F0000h, ready required, three waits.
// - Upper block ends at FFFFFh; lower boundary field sets its start.
// - Upper select ready bit ignores ready when set; bits 1-0 give 0-3 waits.
// - Pin-function bit makes lines 6, 5 selects when 1, latched a2, a1 when 0.
// - Space bit 1 answers memory cycles, 0 answers I/O cycles.
module chip_select_decoder
   import chip_select_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [AXI_ADDR_W-1:0] s_axil_awaddr,
   input  wire logic                  s_axil_awvalid,
   output logic                       s_axil_awready,
   input  wire logic [AXI_DATA_W-1:0] s_axil_wdata,
   input  wire logic [3:0]            s_axil_wstrb,
   input  wire logic                  s_axil_wvalid,
   output logic                       s_axil_wready,
   output logic [1:0]                 s_axil_bresp,
   output logic                       s_axil_bvalid,
   input  wire logic                  s_axil_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axil_araddr,
   input  wire logic                  s_axil_arvalid,
   output logic                       s_axil_arready,
   output logic [AXI_DATA_W-1:0]      s_axil_rdata,
   output logic [1:0]                 s_axil_rresp,
   output logic                       s_axil_rvalid,
   input  wire logic                  s_axil_rready,
   input  wire logic                  cyc_start,
   input  wire bus_cycle_t            cyc_req,
   output logic                       cyc_done,
   input  wire logic                  ext_ready,
   input  wire logic                  addr_enable_strap_n,
   output logic                       upper_sel_n,
   output logic                       low_sel_n,
   output logic [6:0]                 periph_sel_n,
   output logic                       addr_drive_en,
   output logic                       refreshed_ram_mode
);

   // ***********************************************************
   // Functions
   // ***********************************************************
   function automatic reg_sel_t decode_reg(input logic [AXI_ADDR_W-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a == {IDX_UPPER, 2'b00})
         s = SEL_UPPER;
      else if (a == {IDX_LOW, 2'b00})
         s = SEL_LOW;
      else if (a == {IDX_PERIPH, 2'b00})
         s = SEL_PERIPH;
      else if (a == {IDX_AUX, 2'b00})
         s = SEL_AUX;
      else if (a == {IDX_STATUS, 2'b00})
         s = SEL_STATUS;
      return s;
   endfunction

   function automatic logic [CFG_W-1:0] merge_lanes(input logic [CFG_W-1:0] old_v,
                                                    input logic [AXI_DATA_W-1:0] d,
                                                    input logic [3:0] strb);
      logic [CFG_W-1:0] r;
      r = old_v;
      if (strb[0])
         r[7:0] = d[7:0];
      if (strb[1])
         r[15:8] = d[15:8];
      return r;
   endfunction

   function automatic logic [3:0] periph_waits(input logic [CFG_W-1:0] cfg);
      logic [2:0] code;
      logic [3:0] n;
      code = {cfg[WAIT_HI_POS], cfg[WAIT_LO_POS+1], cfg[WAIT_LO_POS]};
      unique case (code)
         3'b000 : n = 4'h0;
         3'b001 : n = 4'h1;
         3'b010 : n = 4'h2;
         3'b011 : n = 4'h3;
         3'b100 : n = 4'h5;
         3'b101 : n = 4'h7;
         3'b110 : n = 4'h9;
         3'b111 : n = 4'hF;
      endcase
      return n;
   endfunction

   function automatic logic [3:0] short_waits(input logic [CFG_W-1:0] cfg);
      return {2'b00, cfg[WAIT_LO_POS+1:WAIT_LO_POS]};
   endfunction

   // ***********************************************************
   // Registers and state
   // ***********************************************************
   logic [CFG_W-1:0]      upper_cfg_reg;
   logic [CFG_W-1:0]      low_cfg_reg;
   logic [CFG_W-1:0]      periph_cfg_reg;
   logic [CFG_W-1:0]      aux_cfg_reg;
   logic                  low_enabled_reg;
   logic                  periph_written_reg;
   logic                  aux_written_reg;
   logic                  aw_held_reg;
   logic                  w_held_reg;
   logic [AXI_ADDR_W-1:0] aw_addr_reg;
   logic [AXI_DATA_W-1:0] w_data_reg;
   logic [3:0]            w_strb_reg;
   logic                  ready_sync1_reg;
   logic                  ready_sync2_reg;
   logic                  strap_sync1_reg;
   logic                  strap_sync2_reg;
   logic                  strap_taken_reg;
   logic                  strap_force_reg;
   cyc_state_t            cyc_state_reg;
   logic [3:0]            wait_cnt_reg;
   logic                  ready_ignore_reg;
   logic [1:0]            last_hit_reg;

   logic                  wr_fire;
   reg_sel_t              wr_sel;
   logic                  periph_active;

   assign wr_fire       = aw_held_reg && w_held_reg && !s_axil_bvalid;
   assign wr_sel        = decode_reg(aw_addr_reg);
   assign periph_active = periph_written_reg && aux_written_reg;

   // ***********************************************************
   // AXI4-Lite write channels
   // ***********************************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aw_held_reg    <= 1'b0;
         s_axil_awready <= 1'b0;
         aw_addr_reg    <= '0;
      end
      else if (s_axil_awvalid && s_axil_awready)
      begin
         aw_addr_reg    <= s_axil_awaddr;
         aw_held_reg    <= 1'b1;
         s_axil_awready <= 1'b0;
      end
      else if (wr_fire)
         aw_held_reg <= 1'b0;
      else if (!aw_held_reg && !s_axil_bvalid)
         s_axil_awready <= 1'b1;

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         w_held_reg    <= 1'b0;
         s_axil_wready <= 1'b0;
         w_data_reg    <= '0;
         w_strb_reg    <= '0;
      end
      else if (s_axil_wvalid && s_axil_wready)
      begin
         w_data_reg    <= s_axil_wdata;
         w_strb_reg    <= s_axil_wstrb;
         w_held_reg    <= 1'b1;
         s_axil_wready <= 1'b0;
      end
      else if (wr_fire)
         w_held_reg <= 1'b0;
      else if (!w_held_reg && !s_axil_bvalid)
         s_axil_wready <= 1'b1;

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axil_bvalid <= 1'b0;
         s_axil_bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axil_bvalid <= 1'b1;
         s_axil_bresp  <= (wr_sel == SEL_NONE || wr_sel == SEL_STATUS) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axil_bready)
         s_axil_bvalid <= 1'b0;

   // ***********************************************************
   // Configuration registers
   // ***********************************************************
   always_ff @(posedge aclk)
      if (!aresetn)
         upper_cfg_reg <= UPPER_RESET;
      else if (wr_fire && wr_sel == SEL_UPPER)
         upper_cfg_reg <= merge_lanes(upper_cfg_reg, w_data_reg, w_strb_reg);

   // Any write enables the low select, even one with no byte lanes set
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         low_cfg_reg     <= LOW_RESET;
         low_enabled_reg <= 1'b0;
      end
      else if (wr_fire && wr_sel == SEL_LOW)
      begin
         low_cfg_reg     <= merge_lanes(low_cfg_reg, w_data_reg, w_strb_reg);
         low_enabled_reg <= 1'b1;
      end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         periph_cfg_reg     <= PERIPH_RESET;
         periph_written_reg <= 1'b0;
      end
      else if (wr_fire && wr_sel == SEL_PERIPH)
      begin
         periph_cfg_reg     <= merge_lanes(periph_cfg_reg, w_data_reg, w_strb_reg);
         periph_written_reg <= 1'b1;
      end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aux_cfg_reg     <= AUX_RESET;
         aux_written_reg <= 1'b0;
      end
      else if (wr_fire && wr_sel == SEL_AUX)
      begin
         aux_cfg_reg     <= merge_lanes(aux_cfg_reg, w_data_reg, w_strb_reg);
         aux_written_reg <= 1'b1;
      end

   always_ff @(posedge aclk)
      if (!aresetn)
         refreshed_ram_mode <= 1'b0;
      else
         refreshed_ram_mode <= low_enabled_reg && low_cfg_reg[RAM_MODE_POS];

   // ***********************************************************
   // AXI4-Lite read channel
   // ***********************************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid  <= 1'b0;
         s_axil_rdata   <= '0;
         s_axil_rresp   <= RESP_OKAY;
      end
      else if (s_axil_arvalid && s_axil_arready)
      begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid  <= 1'b1;
         s_axil_rresp   <= RESP_OKAY;
         unique case (decode_reg(s_axil_araddr))
            SEL_UPPER  : s_axil_rdata <= {16'h0000, upper_cfg_reg};
            SEL_LOW    : s_axil_rdata <= {16'h0000, low_cfg_reg};
            SEL_PERIPH : s_axil_rdata <= {16'h0000, periph_cfg_reg};
            SEL_AUX    : s_axil_rdata <= {16'h0000, aux_cfg_reg};
            SEL_STATUS : s_axil_rdata <= {24'h00_0000, last_hit_reg, strap_force_reg, aux_written_reg,
                                          periph_written_reg, low_enabled_reg, periph_active,
                                          cyc_state_reg == CYC_ACTIVE};
            SEL_NONE   :
            begin
               s_axil_rdata <= '0;
               s_axil_rresp <= RESP_SLVERR;
            end
            default    :
            begin
               s_axil_rdata <= '0;
               s_axil_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axil_rvalid && s_axil_rready)
         s_axil_rvalid <= 1'b0;
      else if (!s_axil_rvalid)
         s_axil_arready <= 1'b1;

   // ***********************************************************
   // Pin synchronisers and strap capture
   // ***********************************************************
   // Left out of reset so the strap is already settled at release
   always_ff @(posedge aclk)
   begin
      ready_sync1_reg <= ext_ready;
      ready_sync2_reg <= ready_sync1_reg;
      strap_sync1_reg <= addr_enable_strap_n;
      strap_sync2_reg <= strap_sync1_reg;
   end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         strap_taken_reg <= 1'b0;
         strap_force_reg <= 1'b0;
      end
      else if (!strap_taken_reg)
      begin
         strap_taken_reg <= 1'b1;
         strap_force_reg <= !strap_sync2_reg;
      end

   // ***********************************************************
   // Address decode for a starting bus cycle
   // ***********************************************************
   logic        upper_hit;
   logic        low_hit;
   logic        periph_hit;
   logic        space_ok;
   logic [19:0] periph_base;
   logic [19:0] periph_off;
   logic [2:0]  periph_line;
   logic        pins_as_selects;

   assign pins_as_selects = aux_cfg_reg[PIN_FUNC_POS];
   assign periph_base     = {periph_cfg_reg[CFG_W-1:BASE_POS], 11'h000};
   assign periph_off      = cyc_req.addr - periph_base;
   assign periph_line     = periph_off[10:8];

   // I/O cycles match on the full compare; software keeps the base top nibble zero
   assign space_ok = aux_cfg_reg[SPACE_POS] ? cyc_req.is_mem
                     : (!cyc_req.is_mem && cyc_req.addr[19:16] == IO_TOP_NIBBLE);

   assign upper_hit = cyc_req.is_mem
                      && cyc_req.addr >= {1'b1, upper_cfg_reg[BOUNDARY_POS+2:BOUNDARY_POS], BLOCK_LOW16};
   assign low_hit   = cyc_req.is_mem && low_enabled_reg
                      && cyc_req.addr <= {1'b0, low_cfg_reg[BOUNDARY_POS+2:BOUNDARY_POS], BLOCK_HIGH16};
   assign periph_hit = periph_active && space_ok && periph_off < PCS_SPAN
                       && periph_line != PCS_HOLE_LINE
                       && (periph_line <= PCS_LINE_HIGH || pins_as_selects);

   // ***********************************************************
   // Bus cycle sequencing
   // ***********************************************************
   logic cyc_accept;
   logic cyc_finish;

   assign cyc_accept = cyc_start && cyc_state_reg == CYC_IDLE;
   assign cyc_finish = cyc_state_reg == CYC_ACTIVE && wait_cnt_reg == WAIT_NONE
                       && (ready_ignore_reg || ready_sync2_reg);

   always_ff @(posedge aclk)
      if (!aresetn)
         cyc_state_reg <= CYC_IDLE;
      else
         unique case (cyc_state_reg)
            CYC_IDLE   : if (cyc_accept) cyc_state_reg <= CYC_ACTIVE;
            CYC_ACTIVE : if (cyc_finish) cyc_state_reg <= CYC_IDLE;
         endcase

   always_ff @(posedge aclk)
      if (!aresetn)
         cyc_done <= 1'b0;
      else
         cyc_done <= cyc_finish;

   // Waits count down first; ready is only looked at once they are spent
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         wait_cnt_reg     <= WAIT_NONE;
         ready_ignore_reg <= 1'b0;
         last_hit_reg     <= 2'b00;
      end
      else if (cyc_accept)
      begin
         if (upper_hit)
         begin
            wait_cnt_reg     <= short_waits(upper_cfg_reg);
            ready_ignore_reg <= upper_cfg_reg[READY_IGN_POS];
            last_hit_reg     <= 2'b01;
         end
         else if (low_hit)
         begin
            wait_cnt_reg     <= short_waits(low_cfg_reg);
            ready_ignore_reg <= low_cfg_reg[READY_IGN_POS];
            last_hit_reg     <= 2'b10;
         end
         else if (periph_hit && periph_line <= PCS_LINE_HIGH)
         begin
            wait_cnt_reg     <= periph_waits(periph_cfg_reg);
            ready_ignore_reg <= periph_cfg_reg[READY_IGN_POS];
            last_hit_reg     <= 2'b11;
         end
         else if (periph_hit)
         begin
            wait_cnt_reg     <= short_waits(aux_cfg_reg);
            ready_ignore_reg <= aux_cfg_reg[READY_IGN_POS];
            last_hit_reg     <= 2'b11;
         end
         else
         begin
            wait_cnt_reg     <= WAIT_NONE;
            ready_ignore_reg <= 1'b0;
            last_hit_reg     <= 2'b00;
         end
      end
      else if (cyc_state_reg == CYC_ACTIVE && wait_cnt_reg != WAIT_NONE)
         wait_cnt_reg <= wait_cnt_reg - WAIT_ONE;

   // ***********************************************************
   // Select and address drive outputs
   // ***********************************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         upper_sel_n <= 1'b1;
         low_sel_n   <= 1'b1;
      end
      else if (cyc_accept)
      begin
         upper_sel_n <= !upper_hit;
         low_sel_n   <= !(low_hit && !upper_hit);
      end
      else if (cyc_finish)
      begin
         upper_sel_n <= 1'b1;
         low_sel_n   <= 1'b1;
      end

   // In address mode lines 6, 5 carry a2, a1 of the last cycle and hold them
   always_ff @(posedge aclk)
      if (!aresetn)
         periph_sel_n <= 7'h7F;
      else if (cyc_accept)
      begin
         for (int i = 0; i < 7; i++)
            periph_sel_n[i] <= !(periph_hit && !upper_hit && !low_hit && periph_line == 3'(i));
         if (periph_active && !pins_as_selects)
         begin
            periph_sel_n[5] <= cyc_req.addr[1];
            periph_sel_n[6] <= cyc_req.addr[2];
         end
      end
      else if (cyc_finish)
      begin
         periph_sel_n[4:0] <= 5'h1F;
         if (pins_as_selects || !periph_active)
            periph_sel_n[6:5] <= 2'b11;
      end

   always_ff @(posedge aclk)
      if (!aresetn)
         addr_drive_en <= 1'b0;
      else if (cyc_accept)
         addr_drive_en <= strap_force_reg
                          || (!low_cfg_reg[ADDR_OFF_POS]
                              && !(upper_hit && upper_cfg_reg[ADDR_OFF_POS]));
      else if (cyc_finish)
         addr_drive_en <= 1'b0;

endmodule
`default_nettype wire

// ### chip_select_pkg.sv
`default_nettype none
package chip_select_pkg;

   // ***********************************************************
   // Widths
   // ***********************************************************
   localparam int AXI_ADDR_W = 12;
   localparam int AXI_DATA_W = 32;
   localparam int CFG_W      = 16;
   localparam int BUS_ADDR_W = 20;

   // ***********************************************************
   // Register indices (byte address is four times the index)
   // ***********************************************************
   localparam logic [9:0] IDX_UPPER  = 10'h0_0A0;
   localparam logic [9:0] IDX_LOW    = 10'h0_0A2;
   localparam logic [9:0] IDX_PERIPH = 10'h0_0A4;
   localparam logic [9:0] IDX_AUX    = 10'h0_0A8;
   localparam logic [9:0] IDX_STATUS = 10'h0_0B0;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [15:0] UPPER_RESET  = 16'hF03B;
   localparam logic [15:0] LOW_RESET    = 16'h0000;
   localparam logic [15:0] PERIPH_RESET = 16'h0000;
   localparam logic [15:0] AUX_RESET    = 16'h0000;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int WAIT_LO_POS     = 0;
   localparam int READY_IGN_POS   = 2;
   localparam int WAIT_HI_POS     = 3;
   localparam int RAM_MODE_POS    = 6;
   localparam int SPACE_POS       = 6;
   localparam int ADDR_OFF_POS    = 7;
   localparam int PIN_FUNC_POS    = 7;
   localparam int BOUNDARY_POS    = 12;
   localparam int BASE_POS        = 7;
   localparam int BASE_SHIFT      = 11;

   // ***********************************************************
   // Decode constants
   // ***********************************************************
   localparam logic [19:0] PCS_SPAN      = 20'h0_0700;
   localparam logic [2:0]  PCS_HOLE_LINE = 3'h4;
   localparam logic [2:0]  PCS_LINE_HIGH = 3'h3;
   localparam logic [15:0] BLOCK_LOW16   = 16'h0000;
   localparam logic [15:0] BLOCK_HIGH16  = 16'hFFFF;
   localparam logic [3:0]  IO_TOP_NIBBLE = 4'h0;
   localparam logic [3:0]  WAIT_NONE     = 4'h0;
   localparam logic [3:0]  WAIT_ONE      = 4'h1;

   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef enum logic [2:0]
   {
      SEL_NONE   = 3'b000,
      SEL_UPPER  = 3'b001,
      SEL_LOW    = 3'b010,
      SEL_PERIPH = 3'b011,
      SEL_AUX    = 3'b100,
      SEL_STATUS = 3'b101
   } reg_sel_t;

   typedef enum logic [0:0]
   {
      CYC_IDLE   = 1'b0,
      CYC_ACTIVE = 1'b1
   } cyc_state_t;

   typedef struct packed
   {
      logic [19:0] addr;
      logic        is_mem;
   } bus_cycle_t;

endpackage
`default_nettype wire

// ### chip_select_decoder_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module chip_select_decoder_assertions
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       cyc_start,
   input wire logic       cyc_done,
   input wire logic       upper_sel_n,
   input wire logic       low_sel_n,
   input wire logic [6:0] periph_sel_n,
   input wire logic       addr_drive_en
);
   // ****************************************
   // Bus cycle relations
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_done_pulse: assert property (cyc_done |=> !cyc_done) else $error("cyc_done longer than one cycle");
   a_done_release: assert property (cyc_done |-> upper_sel_n && low_sel_n && &periph_sel_n[3:0] && !addr_drive_en)
      else $error("select held past cyc_done");
   a_one_select: assert property ($countones({upper_sel_n, low_sel_n, periph_sel_n[3:0]}) >= 5)
      else $error("two selects at once");
   a_hole_unused: assert property (periph_sel_n[4]) else $error("unused window selected");
   a_upper_cause: assert property ($fell(upper_sel_n) |-> $past(cyc_start)) else $error("upper select without start");
   a_low_cause: assert property ($fell(low_sel_n) |-> $past(cyc_start)) else $error("low select without start");
   a_cycle_bound: assert property (cyc_start |-> ##[2:40] cyc_done) else $error("bus cycle never ended");
   a_min_latency: assert property (cyc_start |=> !cyc_done) else $error("bus cycle ended too soon");
endmodule
bind chip_select_decoder chip_select_decoder_assertions chk_i (.aclk, .aresetn, .cyc_start, .cyc_done, .upper_sel_n,
   .low_sel_n, .periph_sel_n, .addr_drive_en);
`default_nettype wire

// ### ext_target.sv
`timescale 1ns/1ns
`default_nettype none
module ext_target
(
   input  wire logic aclk,
   input  wire logic busy,
   input  wire logic slow,
   output var logic  ext_ready
);
   int n = 0;
   // Ready is pulled low outside cycles; slow mode answers only after eight cycles
   always @(posedge aclk)
   begin
      n <= busy ? n + 1 : 0;
      ext_ready <= busy && (!slow || n >= 8);
   end
endmodule
`default_nettype wire

// ### chip_select_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
module chip_select_decoder_test;
   import chip_select_pkg::*;
   logic                  aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready;
   logic                  s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, cyc_start;
   logic                  cyc_done, ext_ready, addr_enable_strap_n, upper_sel_n, low_sel_n, addr_drive_en;
   logic                  refreshed_ram_mode, busy, slow, lw, pw, xw, sf;
   logic [AXI_ADDR_W-1:0] s_axil_awaddr, s_axil_araddr;
   logic [AXI_DATA_W-1:0] s_axil_wdata, s_axil_rdata;
   logic [3:0]            s_axil_wstrb;
   logic [1:0]            s_axil_bresp, s_axil_rresp;
   logic [6:0]            periph_sel_n;
   logic [15:0]           up, lo, pe, ax;
   logic [2:0]            bt [4];
   bus_cycle_t            cyc_req;
   int                    n_fail, compares, cycles, seed, wt [8];
   chip_select_decoder uut (.*);
   ext_target far_i (.aclk, .busy, .slow, .ext_ready);
   initial
   begin
      aclk = 0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000) begin n_fail++; summarize(); end
   end
   task automatic summarize();
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      compares++;
      if (s !== e) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, s); end
   endtask
   task automatic mreset(logic f);
      {up, lo, pe, ax, lw, pw, xw, sf} = {16'hF03B, 48'h0, 3'b000, f};
   endtask
   // ****************************************
   // Register bus master
   // ****************************************
   task automatic wr(logic [9:0] idx, logic [15:0] d);
      s_axil_awaddr <= {idx, 2'b00};
      s_axil_wdata <= {16'h0000, d};
      {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'b111;
      forever
      begin
         @(posedge aclk);
         if (s_axil_awready) s_axil_awvalid <= 1'b0;
         if (s_axil_wready) s_axil_wvalid <= 1'b0;
         if (s_axil_bvalid) break;
      end
      chk("bresp", RESP_OKAY, s_axil_bresp);
      case (idx)
         IDX_UPPER: up = d;
         IDX_LOW: {lw, lo} = {1'b1, d};
         IDX_PERIPH: {pw, pe} = {1'b1, d};
         default: {xw, ax} = {1'b1, d};
      endcase
   endtask
   task automatic rd(logic [9:0] idx, logic [15:0] e, logic [1:0] er);
      s_axil_araddr <= {idx, 2'b00};
      {s_axil_arvalid, s_axil_rready} <= 2'b11;
      forever
      begin
         @(posedge aclk);
         if (s_axil_arready) s_axil_arvalid <= 1'b0;
         if (s_axil_rvalid) break;
      end
      chk("rdata", {16'h0000, e}, s_axil_rdata);
      chk("rresp", er, s_axil_rresp);
   endtask
   // ****************************************
   // Decode model and bus cycles
   // ****************************************
   task automatic cyc(logic [19:0] a, logic m);
      logic [19:0] off;
      logic [15:0] r;
      logic [8:0]  v;
      int          k, s, w, n;
      off = a - {pe[15:7], 11'h000};
      k = int'(off[10:8]);
      v = 9'h1FF;
      s = -1;
      if (pw && xw && !ax[7]) v[6:5] = a[2:1];
      if (m && a[19:16] >= {1'b1, up[14:12]}) s = 8;
      else if (lw && m && a[19:16] <= {1'b0, lo[14:12]}) s = 7;
      else if (pw && xw && off < 20'h0_0700 && k != 4 && (ax[6] ? m : !m && a[19:16] == 4'h0) && (k < 4 || ax[7])) s = k;
      r = s == 8 ? up : s == 7 ? lo : s > 4 ? ax : pe;
      if (s >= 0) v[s] = 1'b0;
      w = s < 0 ? 0 : s < 4 ? wt[{r[3], r[1:0]}] : int'(r[1:0]);
      cyc_req <= '{a, m};
      {cyc_start, busy} <= 2'b11;
      n = 0;
      do
      begin
         @(posedge aclk);
         cyc_start <= 1'b0;
         #1 n++;
         if (n == 1) chk("sel", v, {upper_sel_n, low_sel_n, periph_sel_n});
         if (n == 1) chk("drive", sf || !(lo[7] || s == 8 && up[7]), addr_drive_en);
         if (n == 1) chk("ram", lw && lo[6], refreshed_ram_mode);
      end
      while (cyc_done !== 1'b1 && n < 60);
      if (s >= 0 && r[2]) chk("wait", 2 + w, n);
      else chk("late", slow ? 12 : w > 2 ? 2 + w : 4, n);
      busy <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   initial
   begin
      {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready, cyc_start, busy, slow} = 0;
      {s_axil_awaddr, s_axil_araddr, s_axil_wdata, cyc_req, aresetn} = 0;
      {s_axil_wstrb, addr_enable_strap_n, seed, n_fail, compares, cycles} = {4'hF, 1'b1, 32'h1498_5e34, 96'h0};
      wt = '{0, 1, 2, 3, 5, 7, 9, 15};
      bt = '{3'b000, 3'b001, 3'b011, 3'b111};
      mreset(1'b0);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(IDX_UPPER, 16'hF03B, RESP_OKAY);
      rd(10'h0_0A6, 16'h0000, RESP_SLVERR);
      cyc(20'hF_0000 | 20'($random(seed) & 16'hFFFF), 1'b1);
      cyc(20'h0_0100, 1'b1);
      cyc(20'h0_2000, 1'b0);
      foreach (bt[i])
      begin
         wr(IDX_LOW, {1'b0, bt[i], 12'hF3C} | 16'(i));
         cyc({1'b0, bt[i], 16'hFFFF}, 1'b1);
         cyc({1'b0, bt[i], 16'hFFFF} + 20'h0_0001, 1'b1);
         wr(IDX_UPPER, {1'b1, ~bt[i], 12'hF3C} | 16'(i));
         cyc({1'b1, ~bt[i], 16'h0000}, 1'b1);
         cyc({1'b1, ~bt[i], 16'h0000} - 20'h0_0001, 1'b1);
      end
      rd(IDX_LOW, lo, RESP_OKAY);
      wr(IDX_PERIPH, 16'h0270);
      cyc(20'h0_2000, 1'b0);
      wr(IDX_AUX, 16'hFFBF);
      for (int c = 0; c < 8; c++)
      begin
         wr(IDX_PERIPH, {9'h004, 3'b111, 1'(c >> 2), 1'b1, 2'(c)});
         cyc(20'h0_2000 + 20'(256 * (c % 4)) + 20'($random(seed) & 255), 1'b0);
      end
      foreach (bt[i]) cyc(20'h0_2400 + 20'(256 * i) + 20'(i * 85), 1'b0);
      wr(IDX_AUX, 16'hFFFF);
      cyc(20'h0_2000, 1'b0);
      wr(IDX_AUX, 16'hFF3F);
      cyc(20'h0_2004, 1'b0);
      wr(IDX_LOW, 16'h7F38);
      slow <= 1'b1;
      cyc(20'h0_0010, 1'b1);
      slow <= 1'b0;
      wr(IDX_LOW, 16'h7FBC);
      cyc(20'h0_0020, 1'b1);
      wr(IDX_UPPER, 16'hFFBC);
      wr(IDX_LOW, 16'h7F7C);
      cyc(20'hF_FFF0, 1'b1);
      cyc(20'h0_0030, 1'b1);
      {aresetn, addr_enable_strap_n} <= 2'b00;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      mreset(1'b1);
      @(posedge aclk);
      wr(IDX_UPPER, 16'hFFBC);
      cyc(20'hF_1234, 1'b1);
      cyc(20'h0_0040, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
